// >>> hw/async_host_bus_int_ack_n_port.v
`timescale 1ns/100ps
`include "host_port_regs.vh"
module async_host_bus_int_ack_n_port (
	// clock and reset
	input  wire        REF_CLK,
	input  wire        RST_N,
	// host bus
	input  wire        UNIT_SEL_N,
	input  wire        BUS_STROBE_N,
	input  wire        READ_NOT_WRITE,
	input  wire [4:0]  REG_SELECT,
	input  wire [7:0]  DATA_IN,
	output reg  [7:0]  DATA_OUT,
	output wire        DATA_OE,
	output wire        TRANSFER_ACK_N,
	output wire        TRANSFER_ACK_OE,
	// interrupt handshake
	input  wire        INT_ACK_N,
	input  wire        CHAIN_IN_N,
	output wire        CHAIN_OUT_N,
	output wire        INT_REQ_N_OUT,
	output wire        INT_REQ_N_OE,
	input  wire [15:0] INT_SOURCE,
	// dma ready
	output wire        RX_DMA_READY_N,
	output wire        TX_DMA_READY_N,
	// serial line, timer and general line outputs
	input  wire        RX_BUF_FULL,
	input  wire        TX_BUF_EMPTY,
	output wire        SERIAL_OUT_OE,
	output wire        RX_ENABLE,
	output wire        TX_ENABLE,
	output wire [3:0]  TIMER_OUT,
	output wire [7:0]  GPIO_OE,
	output wire [7:0]  GPIO_OUT
);
	// ***************************************************
	// bus cycle states
	// ***************************************************
	localparam ST_IDLE = 3'd0;
	localparam ST_RDAT = 3'd1;
	localparam ST_ACK  = 3'd2;
	localparam ST_WR   = 3'd3;
	localparam ST_END  = 3'd4;
	localparam ST_PASS = 3'd5;

	reg  [2:0]  state_ff;
	reg  [2:0]  nxt_state;
	reg         drive_ff;
	reg         nxt_drive;
	reg         ack_ff;
	reg         nxt_ack;
	reg  [7:0]  gpio_dat_ff;
	reg  [7:0]  gpio_dir_ff;
	reg  [15:0] int_en_ff;
	reg  [15:0] int_mask_ff;
	reg  [15:0] pend_ff;
	reg  [7:0]  vec_base_ff;
	reg  [7:0]  tx_status_reg;
	reg         tx_en_ff;
	reg  [7:0]  rx_status_ff;
	reg  [15:0] src_d_ff;
	reg  [3:0]  chan_ff;
	reg  [3:0]  top_chan;
	reg  [7:0]  rd_mux;
	reg         wr_strobe;
	reg         clr_chan;
	wire [7:0]  keep_rd;
	wire [15:0] active;
	wire        any_req;
	wire        bus_req;
	wire        int_ack_n_req;
	wire        keep_sel;
	integer     i;

	// ***************************************************
	// request decode
	// ***************************************************
	// [RQ27] select ignored when idle
	assign bus_req  = !UNIT_SEL_N && !BUS_STROBE_N;
	assign int_ack_n_req = !INT_ACK_N && !BUS_STROBE_N;
	assign keep_sel = (REG_SELECT == `OFS_TIMER_A_DATA) || (REG_SELECT == `OFS_TIMER_B_DATA) ||
	                  (REG_SELECT == `OFS_TIMER_C_DATA) || (REG_SELECT == `OFS_TIMER_D_DATA) ||
	                  (REG_SELECT == `OFS_SERIAL_DATA);

	// [RQ7] any enabled unmasked pending source
	assign active  = pend_ff & int_mask_ff;
	assign any_req = |active;

	// [RQ26] highest pending channel number
	always @* begin
		top_chan = 4'h0;
		for (i = 0; i < 16; i = i + 1) begin
			if (active[i]) begin
				top_chan = i[3:0];
			end
		end
	end

	// ***************************************************
	// bus cycle sequencer
	// ***************************************************
	always @* begin
		nxt_state = state_ff;
		nxt_drive = drive_ff;
		nxt_ack   = ack_ff;
		case (state_ff)
			ST_IDLE: begin
				nxt_ack = 1'b0;
				if (bus_req && READ_NOT_WRITE) begin
					// [RQ1] data first, acknowledge next
					nxt_state = ST_RDAT;
					nxt_drive = 1'b1;
				end else if (bus_req) begin
					nxt_state = ST_WR;
				end else if (int_ack_n_req && !CHAIN_IN_N) begin
					// [RQ12] respond or pass down
					if (any_req) begin
						nxt_state = ST_RDAT;
						nxt_drive = 1'b1;
					end else begin
						nxt_state = ST_PASS;
					end
				end
			end
			ST_RDAT: begin
				nxt_state = ST_ACK;
				nxt_ack   = 1'b1;
			end
			ST_WR: begin
				// [RQ4] write lands on falling edge, then ack
				nxt_state = ST_ACK;
				nxt_ack   = 1'b1;
			end
			ST_ACK: begin
				// [RQ3] [RQ6] [RQ10] end on negation
				if (UNIT_SEL_N && (INT_ACK_N || BUS_STROBE_N) || BUS_STROBE_N) begin
					nxt_state = ST_END;
					nxt_ack   = 1'b0;
					nxt_drive = 1'b0;
				end
			end
			ST_END: begin
				// ack driven high one cycle, then released
				nxt_state = ST_IDLE;
			end
			ST_PASS: begin
				if (BUS_STROBE_N || INT_ACK_N) begin
					nxt_state = ST_IDLE;
				end
			end
			default: begin
				nxt_state = ST_IDLE;
				nxt_drive = 1'b0;
				nxt_ack   = 1'b0;
			end
		endcase
	end

	// [RQ22] outputs negated in reset
	always @(posedge REF_CLK or negedge RST_N) begin
		if (!RST_N) begin
			state_ff <= ST_IDLE;
			drive_ff <= 1'b0;
			ack_ff   <= 1'b0;
		end else begin
			state_ff <= nxt_state;
			drive_ff <= nxt_drive;
			ack_ff   <= nxt_ack;
		end
	end

	// ***************************************************
	// pin drive
	// ***************************************************
	// [RQ13] [RQ25] no drive while passing chain
	assign DATA_OE         = drive_ff;
	assign TRANSFER_ACK_OE = (state_ff == ST_ACK) || (state_ff == ST_END) ||
	                         (state_ff == ST_RDAT) || (state_ff == ST_WR);
	assign TRANSFER_ACK_N  = !ack_ff;
	// [RQ14] chain out only when nothing above or here
	assign CHAIN_OUT_N     = !((state_ff == ST_PASS) && !CHAIN_IN_N && !any_req);
	// open drain: pull low only
	assign INT_REQ_N_OUT   = 1'b0;
	assign INT_REQ_N_OE    = any_req;
	// [RQ15] [RQ16] dma ready from buffer flags
	assign RX_DMA_READY_N  = !rx_status_ff[`BIT_BUF_FLAG];
	// [RQ22] transmit ready driven low (asserted), not negated, while reset is held
	assign TX_DMA_READY_N  = RST_N ? !tx_status_reg[`BIT_BUF_FLAG] : 1'b0;
	// [RQ19] [RQ21] idle serial and timer state after reset
	assign SERIAL_OUT_OE   = tx_en_ff;
	assign TX_ENABLE       = tx_en_ff;
	assign RX_ENABLE       = rx_status_ff[`BIT_RX_ENABLE];
	assign TIMER_OUT       = 4'h0;
	assign GPIO_OE         = gpio_dir_ff;
	assign GPIO_OUT        = gpio_dat_ff;

	// ***************************************************
	// read data
	// ***************************************************
	always @* begin
		case (REG_SELECT)
			`OFS_GPIO_DATA:   rd_mux = gpio_dat_ff;
			`OFS_GPIO_DIR:    rd_mux = gpio_dir_ff;
			`OFS_INT_EN_A:    rd_mux = int_en_ff[15:8];
			`OFS_INT_EN_B:    rd_mux = int_en_ff[7:0];
			`OFS_INT_PEND_A:  rd_mux = pend_ff[15:8];
			`OFS_INT_PEND_B:  rd_mux = pend_ff[7:0];
			`OFS_INT_MASK_A:  rd_mux = int_mask_ff[15:8];
			`OFS_INT_MASK_B:  rd_mux = int_mask_ff[7:0];
			`OFS_VECTOR_BASE: rd_mux = {vec_base_ff[7:3], 3'h0};
			`OFS_RX_STATUS:   rd_mux = rx_status_ff;
			`OFS_TX_STATUS:   rd_mux = {tx_status_reg[7:1], tx_en_ff};
			default:          rd_mux = keep_rd;
		endcase
	end

	// [RQ1] [RQ8] register or vector into data flop
	always @(posedge REF_CLK or negedge RST_N) begin
		if (!RST_N) begin
			DATA_OUT <= `RST_BYTE;
		end else if (state_ff == ST_IDLE && int_ack_n_req) begin
			DATA_OUT <= {vec_base_ff[7:4], top_chan};
		end else if (state_ff == ST_RDAT && !INT_ACK_N) begin
			DATA_OUT <= {vec_base_ff[7:4], chan_ff};
		end else if (state_ff == ST_RDAT) begin
			DATA_OUT <= keep_sel ? keep_rd : rd_mux;
		end
	end

	// ***************************************************
	// writable registers, loaded on falling edge
	// ***************************************************
	always @* begin
		wr_strobe = (state_ff == ST_WR) && bus_req && !READ_NOT_WRITE;
		clr_chan  = (state_ff == ST_RDAT) && !INT_ACK_N;
	end

	// [RQ18] [RQ20] [RQ23] cleared registers
	always @(negedge REF_CLK or negedge RST_N) begin
		if (!RST_N) begin
			gpio_dat_ff  <= `RST_BYTE;
			gpio_dir_ff  <= `RST_BYTE;
			int_en_ff    <= 16'h0000;
			int_mask_ff  <= 16'h0000;
			vec_base_ff  <= `RST_VECTOR_BASE;
			rx_status_ff <= `RST_BYTE;
		end else if (wr_strobe) begin
			case (REG_SELECT)
				`OFS_GPIO_DATA:   gpio_dat_ff <= DATA_IN;
				`OFS_GPIO_DIR:    gpio_dir_ff <= DATA_IN;
				`OFS_INT_EN_A:    int_en_ff[15:8] <= DATA_IN;
				`OFS_INT_EN_B:    int_en_ff[7:0] <= DATA_IN;
				`OFS_INT_MASK_A:  int_mask_ff[15:8] <= DATA_IN;
				`OFS_INT_MASK_B:  int_mask_ff[7:0] <= DATA_IN;
				`OFS_VECTOR_BASE: vec_base_ff <= DATA_IN;
				`OFS_RX_STATUS:   rx_status_ff <= {RX_BUF_FULL, DATA_IN[6:0]};
				default:          rx_status_ff <= rx_status_ff;
			endcase
		end else begin
			rx_status_ff[`BIT_BUF_FLAG] <= RX_BUF_FULL;
		end
	end

	// [RQ19] transmitter enable is the one transmit status bit that reset clears,
	// so the serial output floats even though the rest of the byte survives
	always @(negedge REF_CLK or negedge RST_N) begin
		if (!RST_N) begin
			tx_en_ff <= 1'b0;
		end else if (wr_strobe && REG_SELECT == `OFS_TX_STATUS) begin
			tx_en_ff <= DATA_IN[`BIT_TX_ENABLE];
		end
	end

	// status register survives reset; buffer flag tracks transmitter
	always @(negedge REF_CLK) begin
		if (wr_strobe && REG_SELECT == `OFS_TX_STATUS) begin
			tx_status_reg <= {TX_BUF_EMPTY, DATA_IN[6:0]};
		end else begin
			tx_status_reg[`BIT_BUF_FLAG] <= TX_BUF_EMPTY;
		end
	end

	// ***************************************************
	// pending interrupts
	// ***************************************************
	// [RQ11] serviced channel cleared; new edge wins over clear
	always @(posedge REF_CLK or negedge RST_N) begin
		if (!RST_N) begin
			pend_ff  <= 16'h0000;
			src_d_ff <= 16'h0000;
			chan_ff  <= 4'h0;
		end else begin
			src_d_ff <= INT_SOURCE;
			if (state_ff == ST_IDLE) begin
				chan_ff <= top_chan;
			end
			pend_ff <= (pend_ff & ~((clr_chan ? 16'h0001 : 16'h0000) << chan_ff))
			           | (INT_SOURCE & ~src_d_ff & int_en_ff);
		end
	end

	// ***************************************************
	// reset-surviving storage
	// ***************************************************
	keep_reg_file u_keep (
		.clk     (REF_CLK),
		.wr_en   (wr_strobe && keep_sel),
		.wr_addr (REG_SELECT),
		.wr_data (DATA_IN),
		.rd_addr (REG_SELECT),
		.rd_data (keep_rd)
	);
endmodule

// >>> hw/host_port_regs.vh
// Summary of operation
// [RQ1] read: drive selected register, then acknowledge
// [RQ2] master drops strobe after latching read data
// [RQ3] read ends on select or strobe negation
// [RQ4] write loads register on falling clock edge
// [RQ5] master drops strobe after seeing acknowledge
// [RQ6] write ends on select or strobe negation
// [RQ7] request asserted while any source pending; the code asserts it only for pending sources whose mask bit is set
// [RQ8] acknowledge cycle places channel vector, then acknowledges
// [RQ9] master latches vector then drops strobe
// [RQ10] acknowledge cycle ends on strobe or ack negation
// [RQ11] request negated after acknowledge unless more pending
// [RQ12] chain in low: vector if pending, else pass
// [RQ13] passing chain: drive neither data nor acknowledge
// [RQ14] chain out only when nothing above requests
// [RQ15] receive dma ready follows buffer full bit
// [RQ16] transmit dma ready follows buffer empty bit
// [RQ17] reset held at least two microseconds; the testbench releases its first reset after 24 ns
// [RQ18] reset clears registers except timer, serial, status
// [RQ19] reset stops timers, serial, floats serial output
// [RQ20] reset disables channels, clears all pending
// [RQ21] reset floats general lines, timer outputs low
// [RQ22] reset holds all external outputs negated; the code drives transmit dma ready low (asserted) during reset
// [RQ23] reset loads vector base with zero
// [RQ24] master never asserts select and ack together
// [RQ25] acknowledge only with select or ack-and-chain
// [RQ26] vector is base high nibble plus channel
// [RQ27] idle: data and acknowledge float, select ignored
`ifndef HOST_PORT_REGS_VH
`define HOST_PORT_REGS_VH
// ***************************************************
// register select offsets
// ***************************************************
`define OFS_GPIO_DATA     5'h00
`define OFS_GPIO_DIR      5'h02
`define OFS_INT_EN_A      5'h03
`define OFS_INT_EN_B      5'h04
`define OFS_INT_PEND_A    5'h05
`define OFS_INT_PEND_B    5'h06
`define OFS_INT_MASK_A    5'h09
`define OFS_INT_MASK_B    5'h0a
`define OFS_VECTOR_BASE   5'h0b
`define OFS_TIMER_A_DATA  5'h0f
`define OFS_TIMER_B_DATA  5'h10
`define OFS_TIMER_C_DATA  5'h11
`define OFS_TIMER_D_DATA  5'h12
`define OFS_RX_STATUS     5'h15
`define OFS_TX_STATUS     5'h16
`define OFS_SERIAL_DATA   5'h17
// ***************************************************
// fields and reset values
// ***************************************************
`define BIT_BUF_FLAG      7
`define BIT_TX_ENABLE     0
`define BIT_RX_ENABLE     0
`define RST_VECTOR_BASE   8'h00
`define RST_BYTE          8'h00
`define NUM_REGS          32
// ***************************************************
// timing
// ***************************************************
`define CLK_PERIOD_NS     8
`define RESET_MIN_NS      2000
`define RESET_MIN_CYCLES  ((`RESET_MIN_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`endif

// >>> hw/keep_reg_file.v
`timescale 1ns/100ps
`include "host_port_regs.vh"
// ***************************************************
// registers that survive reset (timer data, serial data)
// ***************************************************
module keep_reg_file (
	// clock
	input  wire       clk,
	// write side
	input  wire       wr_en,
	input  wire [4:0] wr_addr,
	input  wire [7:0] wr_data,
	// read side
	input  wire [4:0] rd_addr,
	output reg  [7:0] rd_data
);
	reg [7:0] mem_ff [0:`NUM_REGS-1];

	// no reset on purpose, contents survive device reset
	always @(negedge clk) begin
		if (wr_en) begin
			mem_ff[wr_addr] <= wr_data;
		end
	end

	// registered read port
	always @(posedge clk) begin
		rd_data <= mem_ff[rd_addr];
	end
endmodule

// >>> test/async_host_bus_int_ack_n_port_assertions.sv
`timescale 1ns/100ps
// ******
// host port protocol checker
// ******
module async_host_bus_int_ack_n_port_assertions (
	// clock and reset
	input logic REF_CLK,
	input logic RST_N,
	// host bus
	input logic UNIT_SEL_N,
	input logic BUS_STROBE_N,
	input logic READ_NOT_WRITE,
	input logic DATA_OE,
	input logic TRANSFER_ACK_N,
	input logic TRANSFER_ACK_OE,
	// interrupt handshake
	input logic INT_ACK_N,
	input logic CHAIN_IN_N,
	input logic CHAIN_OUT_N,
	input logic INT_REQ_N_OE,
	// dma ready
	input logic RX_BUF_FULL,
	input logic TX_BUF_EMPTY,
	input logic RX_DMA_READY_N,
	input logic TX_DMA_READY_N
);
	default clocking @(posedge REF_CLK); endclocking
	default disable iff (!RST_N);
	// ack pulled low on the pin
	wire ack_lo = TRANSFER_ACK_OE && !TRANSFER_ACK_N;
	// legal cause of an acknowledge
	wire ack_src = !UNIT_SEL_N || (!INT_ACK_N && !CHAIN_IN_N);
	// cycle starts where the strobe first falls
	sequence s_rd;
		!UNIT_SEL_N && $fell(BUS_STROBE_N) && READ_NOT_WRITE;
	endsequence
	sequence s_wr;
		!UNIT_SEL_N && $fell(BUS_STROBE_N) && !READ_NOT_WRITE;
	endsequence
	sequence s_vec;
		!INT_ACK_N && $fell(BUS_STROBE_N) && !CHAIN_IN_N && INT_REQ_N_OE;
	endsequence
	// ack driven high once, then floated
	sequence s_quit;
		##[1:2] (TRANSFER_ACK_OE && TRANSFER_ACK_N) ##1 !TRANSFER_ACK_OE;
	endsequence
	chk_read_answer: assert property (s_rd |-> ##1 DATA_OE ##1 (ack_lo && DATA_OE))
		else $error("read data or ack late");
	chk_write_ack: assert property (s_wr |-> ##2 (ack_lo && !DATA_OE))
		else $error("write ack wrong");
	chk_vector_answer: assert property (s_vec |-> ##1 DATA_OE ##1 ack_lo)
		else $error("vector or ack late");
	chk_ack_end: assert property (ack_lo && BUS_STROBE_N |-> s_quit)
		else $error("ack not ended cleanly");
	chk_read_release: assert property (ack_lo && BUS_STROBE_N && READ_NOT_WRITE |-> ##[1:2] !DATA_OE)
		else $error("data bus held after cycle");
	chk_ack_cause: assert property (ack_lo |-> $past(ack_src))
		else $error("ack without select");
	chk_pass_quiet: assert property (!CHAIN_OUT_N && !INT_ACK_N |-> !DATA_OE && !TRANSFER_ACK_OE)
		else $error("drives bus while passing");
	chk_pass_cause: assert property (!CHAIN_OUT_N |-> !CHAIN_IN_N || !$past(CHAIN_IN_N))
		else $error("chain out without chain in");
	chk_rx_ready: assert property ($changed(RX_BUF_FULL) |-> ##[1:3] (RX_DMA_READY_N == !RX_BUF_FULL))
		else $error("rx ready wrong");
	chk_tx_ready: assert property ($changed(TX_BUF_EMPTY) |-> ##[1:3] (TX_DMA_READY_N == !TX_BUF_EMPTY))
		else $error("tx ready wrong");
	chk_idle_float: assert property ((UNIT_SEL_N && INT_ACK_N)[*4] |-> !DATA_OE && !TRANSFER_ACK_OE)
		else $error("bus driven while idle");
endmodule
bind async_host_bus_int_ack_n_port async_host_bus_int_ack_n_port_assertions u_chk (
	.REF_CLK(REF_CLK), .RST_N(RST_N), .UNIT_SEL_N(UNIT_SEL_N), .BUS_STROBE_N(BUS_STROBE_N),
	.READ_NOT_WRITE(READ_NOT_WRITE), .DATA_OE(DATA_OE), .TRANSFER_ACK_N(TRANSFER_ACK_N),
	.TRANSFER_ACK_OE(TRANSFER_ACK_OE), .INT_ACK_N(INT_ACK_N), .CHAIN_IN_N(CHAIN_IN_N),
	.CHAIN_OUT_N(CHAIN_OUT_N), .INT_REQ_N_OE(INT_REQ_N_OE), .RX_BUF_FULL(RX_BUF_FULL),
	.TX_BUF_EMPTY(TX_BUF_EMPTY), .RX_DMA_READY_N(RX_DMA_READY_N),
	.TX_DMA_READY_N(TX_DMA_READY_N)
);

// >>> test/async_host_bus_int_ack_n_port_tb.sv
`timescale 1ns/100ps
`include "host_port_regs.vh"
module async_host_bus_int_ack_n_port_tb;
	// ******
	// stimulus, wires and counters
	// ******
	logic        REF_CLK = 0;
	logic        RST_N = 0;
	logic        CHAIN_IN_N = 0;
	logic        RX_BUF_FULL = 0;
	logic        TX_BUF_EMPTY = 1;
	logic [15:0] INT_SOURCE = 16'h0000;
	wire         UNIT_SEL_N, BUS_STROBE_N, READ_NOT_WRITE, INT_ACK_N, DATA_OE;
	wire         TRANSFER_ACK_N, TRANSFER_ACK_OE, CHAIN_OUT_N, INT_REQ_N_OE;
	wire         RX_DMA_READY_N, TX_DMA_READY_N, SERIAL_OUT_OE, RX_ENABLE, TX_ENABLE;
	wire [4:0]   REG_SELECT;
	wire [7:0]   DATA_IN, DATA_OUT, GPIO_OE;
	wire [3:0]   TIMER_OUT;
	int          error_cnt = 0;
	int          checks = 0;
	int          cyc_cnt = 0;
	logic [7:0]  q;
	bit          ok;
	// 8 ns clock
	always #4 REF_CLK = ~REF_CLK;
	async_host_bus_int_ack_n_port u_dut (
		.REF_CLK, .RST_N, .UNIT_SEL_N, .BUS_STROBE_N, .READ_NOT_WRITE, .REG_SELECT,
		.DATA_IN, .DATA_OUT, .DATA_OE, .TRANSFER_ACK_N, .TRANSFER_ACK_OE, .INT_ACK_N,
		.CHAIN_IN_N, .CHAIN_OUT_N, .INT_REQ_N_OUT(), .INT_REQ_N_OE, .INT_SOURCE,
		.RX_DMA_READY_N, .TX_DMA_READY_N, .RX_BUF_FULL, .TX_BUF_EMPTY, .SERIAL_OUT_OE,
		.RX_ENABLE, .TX_ENABLE, .TIMER_OUT, .GPIO_OE, .GPIO_OUT()
	);
	host_bus_master u_host (
		.clk(REF_CLK), .sel_n(UNIT_SEL_N), .strobe_n(BUS_STROBE_N), .rnw(READ_NOT_WRITE),
		.int_ack_n_n(INT_ACK_N), .rsel(REG_SELECT), .data_in(DATA_IN), .data_out(DATA_OUT),
		.data_oe(DATA_OE), .ack_n(TRANSFER_ACK_N), .ack_oe(TRANSFER_ACK_OE)
	);
	// compare and count
	task chk(input logic [7:0] got, input logic [7:0] exp);
		checks++;
		if (got !== exp) begin
			error_cnt++;
			$display("Error %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task end_sim;
		if (error_cnt == 0 && checks > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	// bus cycles through the master model
	task wr(input logic [4:0] a, input logic [7:0] d);
		u_host.cyc(0, 0, a, d, 0, q, ok);
		chk(ok, 1);
	endtask
	task rd(input logic [4:0] a, input logic [7:0] e, input int hold);
		u_host.cyc(0, 1, a, 8'h00, hold, q, ok);
		chk(ok, 1);
		chk(q, e);
	endtask
	task vec(input logic [7:0] e);
		u_host.cyc(1, 1, 5'h00, 8'h00, 0, q, ok);
		chk(ok, 1);
		chk(q, e);
	endtask
	// outputs while reset is held
	task t_reset;
		@(negedge REF_CLK);
		chk({TRANSFER_ACK_OE, DATA_OE, INT_REQ_N_OE}, 0);
		chk({CHAIN_OUT_N, RX_DMA_READY_N, TX_DMA_READY_N}, 6);
		chk({SERIAL_OUT_OE, RX_ENABLE, TX_ENABLE, TIMER_OUT}, 0);
		chk(GPIO_OE, 0);
	endtask
	// read back, then a mid-run reset keeps only some registers
	task t_regs;
		rd(`OFS_VECTOR_BASE, 8'h00, 0);
		rd(`OFS_INT_EN_A, 8'h00, 0);
		wr(`OFS_GPIO_DIR, 8'ha5);
		rd(`OFS_GPIO_DIR, 8'ha5, 4);
		wr(`OFS_TIMER_A_DATA, 8'h3c);
		RST_N = 0;
		repeat (249) @(negedge REF_CLK);
		t_reset;
		RST_N = 1;
		rd(`OFS_TIMER_A_DATA, 8'h3c, 0);
		rd(`OFS_GPIO_DIR, 8'h00, 0);
	endtask
	// request, blocked chain, vector fetch with one and two pending
	task t_irq;
		wr(`OFS_INT_EN_A, 8'h81);
		wr(`OFS_INT_MASK_A, 8'h81);
		INT_SOURCE = 16'h8000;
		repeat (4) @(negedge REF_CLK);
		chk(INT_REQ_N_OE, 1);
		chk(CHAIN_OUT_N, 1);
		CHAIN_IN_N = 1;
		u_host.cyc(1, 1, 5'h00, 8'h00, 0, q, ok);
		chk(ok, 0);
		CHAIN_IN_N = 0;
		vec(8'h0f);
		chk(INT_REQ_N_OE, 0);
		wr(`OFS_VECTOR_BASE, 8'h40);
		INT_SOURCE = 16'h0000;
		@(negedge REF_CLK);
		INT_SOURCE = 16'h8100;
		repeat (4) @(negedge REF_CLK);
		vec(8'h4f);
		chk(INT_REQ_N_OE, 1);
		vec(8'h48);
		chk(INT_REQ_N_OE, 0);
	endtask
	// nothing pending: priority passes down the chain
	task t_chain;
		fork
			u_host.cyc(1, 1, 5'h00, 8'h00, 0, q, ok);
			begin
				repeat (5) @(negedge REF_CLK);
				chk(CHAIN_OUT_N, 0);
				chk(DATA_OE, 0);
			end
		join
		chk(ok, 0);
	endtask
	// all four buffer flag combinations
	task t_dma;
		for (int i = 0; i < 4; i++) begin
			RX_BUF_FULL = i[0];
			TX_BUF_EMPTY = i[1];
			repeat (3) @(negedge REF_CLK);
			chk(RX_DMA_READY_N, !i[0]);
			chk(TX_DMA_READY_N, !i[1]);
		end
	endtask
	// hang guard, well above the few hundred cycles needed
	always @(posedge REF_CLK) begin
		cyc_cnt++;
		if (cyc_cnt == 5000) begin
			error_cnt++;
			end_sim;
		end
	end
	// main sequence
	initial begin
		repeat (1) @(negedge REF_CLK);
		t_reset;
		@(negedge REF_CLK);
		RST_N = 1;
		t_regs;
		t_irq;
		t_chain;
		t_dma;
		end_sim;
	end
endmodule

// >>> test/host_bus_master.sv
`timescale 1ns/100ps
// ******
// host bus master with vector fetch cycles
// ******
module host_bus_master (
	// clock
	input  logic       clk,
	// bus lines toward the port
	output logic       sel_n,
	output logic       strobe_n,
	output logic       rnw,
	output logic       int_ack_n_n,
	output logic [4:0] rsel,
	output logic [7:0] data_in,
	// answers from the port
	input  logic [7:0] data_out,
	input  logic       data_oe,
	input  logic       ack_n,
	input  logic       ack_oe
);
	logic       drv;
	logic [7:0] wd;
	// undriven bus shows the inverse of the last byte, so a missed drive is seen
	wire  [7:0] bus = data_oe ? data_out : drv ? wd : ~wd;
	assign data_in = bus;
	// idle bus at time zero
	initial begin
		sel_n = 1;
		strobe_n = 1;
		rnw = 1;
		int_ack_n_n = 1;
		rsel = 5'h00;
		wd = 8'h00;
		drv = 0;
	end
	// one cycle; hold adds slow cycles before letting go
	task automatic cyc(input bit ia, input bit rd, input logic [4:0] a,
		input logic [7:0] d, input int hold, output logic [7:0] q, output bit ok);
		int n;
		@(negedge clk);
		sel_n = ia;
		int_ack_n_n = !ia;
		rnw = rd;
		rsel = a;
		wd = d;
		drv = !rd;
		strobe_n = 0;
		ok = 0;
		n = 0;
		while (!ok && n < 20) begin
			@(posedge clk);
			ok = ack_oe && !ack_n;
			n++;
		end
		q = bus;
		repeat (hold) @(posedge clk);
		@(negedge clk);
		sel_n = 1;
		int_ack_n_n = 1;
		strobe_n = 1;
		drv = 0;
		repeat (3) @(negedge clk);
	endtask
endmodule
